// [rtl/card_host_status_irq_bank.v]
// Status flags, interrupt mask and Wishbone slave of the card host interface
// Function
// - rx full when both rx counters zero
// - tx empty when both tx counters zero
// - index mismatch sets flag; command write clears
// - missing direction bit sets direction error
// - response CRC7 failure; command write clears
// - missing end bit; command write clears
// - response latency exceeded; command write clears
// - data CRC16 failure; status read clears
// - data wait exceeded; status read clears
// - lost received byte; new transfer clears
// - byte sent unwritten; new transfer clears
// - per-slot card interrupt; status read clears
// - enable register sets mask bits
// - disable register clears mask bits
// - mask readable, one means enabled
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`include "card_host_map.vh"
module card_host_status_irq_bank #(
  parameter CW = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rstn,
  // Wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // Lower status flags from the command and data path
  input  wire [7:0]    lower_status,
  // Peripheral DMA counters
  input  wire [CW-1:0] receive_counter,
  input  wire [CW-1:0] receive_next_counter,
  input  wire [CW-1:0] transmit_counter,
  input  wire [CW-1:0] transmit_next_counter,
  // Response checker events, one-cycle pulses
  input  wire          rsp_index_mismatch,
  input  wire          rsp_dir_missing,
  input  wire          rsp_crc_fail,
  input  wire          rsp_end_missing,
  input  wire          rsp_latency_exceeded,
  // Data path events, one-cycle pulses
  input  wire          data_crc_fail,
  input  wire          data_wait_exceeded,
  input  wire          rx_byte_lost,
  input  wire          tx_byte_unwritten,
  input  wire          data_cmd_sent,
  // Card interrupt levels from the slot pins
  input  wire          slot_a_irq_pin,
  input  wire          slot_b_irq_pin,
  // Interrupt and command write strobe
  output reg           irq,
  output wire          command_write
);
  reg  [31:0] mask_q;
  reg  [31:0] mask_d;
  reg         a_s1_q;
  reg         a_s2_q;
  reg         a_s3_q;
  reg         b_s1_q;
  reg         b_s2_q;
  reg         b_s3_q;
  wire        rx_full;
  wire        tx_empty;
  wire [31:0] status;
  wire        req;
  wire        wr;
  wire        rd_status;
  wire        slot_a_rise;
  wire        slot_b_rise;
  wire [12:0] set_v;
  wire [12:0] clr_v;
  wire [12:0] flag_v;

  // Single-cycle ack; hold off a second ack while master releases
  assign req           = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr            = req && wb_we_i;
  assign rd_status     = req && !wb_we_i && (wb_adr_i == `OFS_STATUS);
  assign command_write = wr && (wb_adr_i == `OFS_COMMAND);

  // Slot pins come from outside, two flops before use
  always @(posedge clk) begin
    if (!rstn) begin
      a_s1_q <= 1'b0;
      a_s2_q <= 1'b0;
      a_s3_q <= 1'b0;
      b_s1_q <= 1'b0;
      b_s2_q <= 1'b0;
      b_s3_q <= 1'b0;
    end else begin
      a_s1_q <= slot_a_irq_pin;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
      b_s1_q <= slot_b_irq_pin;
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
    end
  end
  assign slot_a_rise = a_s2_q && !a_s3_q;
  assign slot_b_rise = b_s2_q && !b_s3_q;

  counter_zero_flags #(.CW(CW)) u_zero (
    .clk                   (clk),
    .rstn                  (rstn),
    .receive_counter       (receive_counter),
    .receive_next_counter  (receive_next_counter),
    .transmit_counter      (transmit_counter),
    .transmit_next_counter (transmit_next_counter),
    .rx_buffer_full        (rx_full),
    .tx_buffer_empty       (tx_empty)
  );

  // Sticky set vector, order matches flag_v
  // index mismatch
  assign set_v = {slot_b_rise, slot_a_rise, tx_byte_unwritten, rx_byte_lost, data_wait_exceeded,
                  data_crc_fail, rsp_latency_exceeded, rsp_end_missing, rsp_crc_fail,
                  rsp_dir_missing, rsp_index_mismatch, 2'b00};
  // Direction error has no clear; the command write clears its neighbours
  assign clr_v = {rd_status, rd_status, data_cmd_sent, data_cmd_sent, rd_status, rd_status,
                  command_write, command_write, command_write, 1'b0, command_write, 2'b00};

  genvar gi;
  generate
    for (gi = 2; gi < 13; gi = gi + 1) begin : g_flag
      sticky_flag u_flag (
        .clk    (clk),
        .rstn   (rstn),
        .set    (set_v[gi]),
        .clr    (clr_v[gi]),
        .flag_q (flag_v[gi])
      );
    end
  endgenerate
  assign flag_v[1:0] = {tx_empty, rx_full};

  // Status word assembly
  assign status = {flag_v[10], flag_v[9], 7'h00, flag_v[8], flag_v[7], flag_v[6], flag_v[5],
                   flag_v[4], flag_v[3], flag_v[2], flag_v[1], flag_v[0], 4'h0,
                   flag_v[12], flag_v[11], lower_status};

  always @* begin
    mask_d = mask_q;
    if (wr && (wb_adr_i == `OFS_IRQ_ENABLE)) begin
      mask_d = mask_q | (wb_dat_i & `STATUS_IMPL_BITS);
    end else if (wr && (wb_adr_i == `OFS_IRQ_DISABLE)) begin
      mask_d = mask_q & ~wb_dat_i;
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      mask_q   <= `MASK_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq      <= 1'b0;
    end else begin
      mask_q   <= mask_d;
      wb_ack_o <= req;
      irq      <= |(status & mask_q);
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          `OFS_STATUS:   wb_dat_o <= status;
          `OFS_IRQ_MASK: wb_dat_o <= mask_q;
          default:       wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// [rtl/card_host_map.vh]
// Register offsets, bit positions and reset values of the status and interrupt bank
`ifndef CARD_HOST_MAP_VH
`define CARD_HOST_MAP_VH
`define OFS_STATUS        8'h40
`define OFS_IRQ_ENABLE    8'h44
`define OFS_IRQ_DISABLE   8'h48
`define OFS_IRQ_MASK      8'h4c
`define OFS_COMMAND       8'h14
`define OFS_PERIPH_COUNT  8'h50
`define BIT_CMD_READY     0
`define BIT_RX_READY      1
`define BIT_TX_READY      2
`define BIT_BLOCK_END     3
`define BIT_XFER_ACTIVE   4
`define BIT_NOT_BUSY      5
`define BIT_END_RX        6
`define BIT_END_TX        7
`define BIT_SLOT_A_IRQ    8
`define BIT_SLOT_B_IRQ    9
`define BIT_RX_FULL       14
`define BIT_TX_EMPTY      15
`define BIT_RSP_INDEX     16
`define BIT_RSP_DIR       17
`define BIT_RSP_CRC       18
`define BIT_RSP_END       19
`define BIT_RSP_TIMEOUT   20
`define BIT_DATA_CRC      21
`define BIT_DATA_TIMEOUT  22
`define BIT_OVERRUN       30
`define BIT_UNDERRUN      31
`define MASK_RESET        32'h0000_0000
`define STATUS_IMPL_BITS  32'hc07f_c3ff
`endif

// [rtl/sticky_flag.v]
// Sticky event flag where a set wins over a clear in the same cycle
module sticky_flag (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Set and clear
  input  wire set,
  input  wire clr,
  // Flag state
  output reg  flag_q
);
  always @(posedge clk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// [rtl/counter_zero_flags.v]
// Buffer full and empty flags from the peripheral DMA counters
`include "card_host_map.vh"
module counter_zero_flags #(
  parameter CW = 16
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rstn,
  // Peripheral DMA counters
  input  wire [CW-1:0] receive_counter,
  input  wire [CW-1:0] receive_next_counter,
  input  wire [CW-1:0] transmit_counter,
  input  wire [CW-1:0] transmit_next_counter,
  // Registered level flags
  output reg           rx_buffer_full,
  output reg           tx_buffer_empty
);
  always @(posedge clk) begin
    if (!rstn) begin
      rx_buffer_full  <= 1'b1;
      tx_buffer_empty <= 1'b1;
    end else begin
      rx_buffer_full  <= (receive_counter == {CW{1'b0}}) && (receive_next_counter == {CW{1'b0}});
      tx_buffer_empty <= (transmit_counter == {CW{1'b0}}) && (transmit_next_counter == {CW{1'b0}});
    end
  end
endmodule

// [testbench/bank_chk.sv]
// Port assertions for the status and interrupt bank
module bank_chk #(
  parameter CW = 16
) (
  // Clock and reset
  input wire logic          clk,
  input wire logic          rstn,
  // Register bus
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  // Counters, events, outputs
  input wire logic [CW-1:0] receive_counter,
  input wire logic [CW-1:0] receive_next_counter,
  input wire logic          rsp_crc_fail,
  input wire logic          irq,
  input wire logic          command_write
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] m_q;
  wire         req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         rz = receive_counter == '0 && receive_next_counter == '0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow mask, so reads need no model of the design
  always @(posedge clk)
    if (!rstn)
      m_q <= 32'h0;
    else if (req && wb_we_i && wb_adr_i == 8'h44)
      m_q <= m_q | (wb_dat_i & 32'hc07fc3ff);
    else if (req && wb_we_i && wb_adr_i == 8'h48)
      m_q <= m_q & ~wb_dat_i;
  property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_cmd; command_write |-> wb_we_i && wb_adr_i == 8'h14; endproperty
  a_cmd: assert property (p_cmd) else $error("stray command strobe");
  property p_rxf; wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h40) |-> wb_dat_o[14] == $past(rz, 2); endproperty
  a_rxf: assert property (p_rxf) else $error("rx full wrong");
  property p_msk; wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h4c) |-> wb_dat_o == $past(m_q); endproperty
  a_msk: assert property (p_msk) else $error("mask read wrong");
  property p_quiet; $past(m_q) == 32'h0 |-> !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("irq while masked");
  property p_rcrc; rsp_crc_fail && m_q[18] && !wb_cyc_i |-> ##2 irq; endproperty
  a_rcrc: assert property (p_rcrc) else $error("crc irq missing");
  property p_clr; req && wb_we_i && wb_adr_i == 8'h48 && &wb_dat_i |-> ##2 !irq; endproperty
  a_clr: assert property (p_clr) else $error("irq after disable");
  property p_rst; $rose(rstn) |-> !wb_ack_o && wb_dat_o == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("bus busy at reset");
  c_rd: cover property (wb_ack_o && $past(wb_adr_i == 8'h40));
  c_irq: cover property ($rose(irq));
  c_cmd: cover property (command_write);
endmodule
bind card_host_status_irq_bank bank_chk #(.CW(CW)) u_bank_chk (.*);

// [testbench/card_side.sv]
// Card-side source of event pulses and slot interrupt pins
module card_side (
  // Clock and request code
  input  wire logic       clk,
  input  wire logic [3:0] code,
  // Event pulses and slot pins
  output logic      [9:0] ev,
  output logic      [1:0] slot
);
  timeunit 1ns;
  timeprecision 100ps;
  initial ev = 10'h0;
  initial slot = 2'h0;
  // Guard keeps every event a single-cycle pulse
  always @(posedge clk) begin
    ev <= (code != 0 && code < 11 && ev == 0) ? 10'h1 << (code - 1) : 10'h0;
    slot <= {code == 12, code == 11};
  end
endmodule

// [testbench/tb_top.sv]
// Random and corner-case bench for the status and interrupt bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rstn = 0, cyc = 0, we = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wd = 0, rdat, st = 0, mk = 0, r;
  logic [15:0] rc = 0, rn = 0, tc = 0, tn = 0;
  logic [3:0]  code = 0, c;
  logic [9:0]  ev;
  logic [1:0]  slot;
  wire  [31:0] dat;
  wire         ack, irq;
  int          failures = 0, checks_done = 0, i;
  byte         pos[9] = '{16, 17, 18, 19, 20, 21, 22, 30, 31};
  always #5 clk = ~clk;
  card_side u_card_side (.clk(clk), .code(code), .ev(ev), .slot(slot));
  card_host_status_irq_bank #(.CW(16)) u_card_host_status_irq_bank (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .lower_status(8'h0), .receive_counter(rc),
    .receive_next_counter(rn), .transmit_counter(tc), .transmit_next_counter(tn), .rsp_index_mismatch(ev[0]),
    .rsp_dir_missing(ev[1]), .rsp_crc_fail(ev[2]), .rsp_end_missing(ev[3]), .rsp_latency_exceeded(ev[4]),
    .data_crc_fail(ev[5]), .data_wait_exceeded(ev[6]), .rx_byte_lost(ev[7]), .tx_byte_unwritten(ev[8]),
    .data_cmd_sent(ev[9]), .slot_a_irq_pin(slot[0]), .slot_b_irq_pin(slot[1]), .irq(irq), .command_write());
  function automatic logic [31:0] exp_st();
    return st | {16'h0, tc == 0 && tn == 0, rc == 0 && rn == 0, 14'h0};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, we, adr, wd} <= {1'b1, w, a, d};
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    // A missing answer counts as a mismatch
    if (ack !== 1'b1)
      failures++;
    rdat = dat;
    cyc <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic fire(input logic [3:0] k);
    @(posedge clk);
    code <= k;
    @(posedge clk);
    code <= 4'h0;
    // Slot pins cross a synchroniser
    repeat (4) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    r = $urandom(32'h8de3a8ea);
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 8'h4c, 32'h0);
    chk("mask_rst", rdat, 32'h0);
    bus(1'b1, 8'h4c, '1);
    bus(1'b1, 8'h44, '1);
    mk = 32'hc07fc3ff;
    bus(1'b0, 8'h50, 32'h0);
    chk("unmapped", rdat, 32'h0);
    for (i = 0; i < 80; i++) begin
      r = $urandom;
      c = i < 12 ? 4'(i + 1) : 4'($urandom_range(1, 12));
      @(posedge clk);
      {rc, rn, tc, tn} <= {$urandom, $urandom} & {{16{r[3]}}, {16{r[2]}}, {16{r[1]}}, {16{r[0]}}};
      fire(c);
      if (c == 10)
        st &= ~32'hc0000000;
      else if (c < 10)
        st[pos[c - 1]] = 1'b1;
      else
        st[c - 3] = 1'b1;
      if (r[4]) begin
        bus(1'b1, 8'h14, $urandom);
        st &= ~32'h001d0000;
      end
      bus(1'b1, r[5] ? 8'h48 : 8'h44, $urandom);
      mk = r[5] ? mk & ~wd : mk | (wd & 32'hc07fc3ff);
      bus(1'b0, 8'h4c, 32'h0);
      chk("mask", rdat, mk);
      repeat (3) @(posedge clk);
      chk("irq", irq, |(exp_st() & mk));
      bus(1'b0, 8'h40, 32'h0);
      chk("rx_full", rdat[14], rc == 0 && rn == 0);
      chk("tx_empty", rdat[15], tc == 0 && tn == 0);
      chk("slots", rdat[9:8], st[9:8]);
      chk("status", rdat, exp_st());
      st &= ~32'h00600300;
    end
    bus(1'b1, 8'h48, '1);
    repeat (3) @(posedge clk);
    chk("irq_off", irq, 1'b0);
    wrap_up();
  end
  // A pass takes about 20 cycles; about 24 times the whole run
  initial begin
    #400us;
    failures++;
    wrap_up();
  end
endmodule
